// ### logic/hswc_halt_stop_ctrl.sv
/*
  hswc_halt_stop_ctrl: halt and stop entry, wake gating and interrupt enables.
  Assumes the sequencer gives one command pulse at a time in CMD_IN and that
  wake sources and pins are synchronous to CLK_IN.
*/
`timescale 1ns/1ps
module hswc_halt_stop_ctrl #(
  parameter int PA_W = hswc_pkg::PA_W,
  parameter int DEBOUNCE_CYC = hswc_pkg::DEBOUNCE_CYC
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  // sequencer commands
  input wire hswc_pkg::hswc_cmd_t CMD_IN,
  // wake sources
  input wire hswc_pkg::hswc_src_t SRC_IN,
  input wire logic [PA_W-1:0] PORT_A_WAKE_PINS_IN,
  input wire logic [PA_W-1:0] PORT_A_INPUT_MODE_IN,
  // operating mode
  output logic FETCH_EN_OUT,
  output logic CLK_RUN_OUT,
  output logic DISP_LOW_OUT,
  output logic HALT_OUT,
  output logic STOP_OUT,
  // interrupts
  output logic [3:0] IRQ_REQ_OUT,
  output logic [7:0] IRQ_VECTOR_OUT,
  // status
  output logic PORT_START_FLAG_OUT,
  output logic STOP_WAKE_FLAG_OUT,
  output logic PORT_STOP_REQ_OUT,
  output logic [3:0] HALT_REQ_OUT
);

  hswc_pkg::hswc_state_t state_reg;
  hswc_pkg::hswc_state_t state_next;
  logic port_chg_en_reg;
  logic [2:0] halt_en_reg;
  logic [3:0] irq_en_reg;
  logic stop_en_reg;
  logic port_stop_req_reg;
  logic stop_wake_flag_reg;
  logic port_start_flag_reg;
  logic port_irq_inh_reg;
  logic resume_stop_reg;
  logic [3:0] irq_req_reg;
  logic [7:0] vec_reg;
  logic fetch_reg;
  logic clk_run_reg;
  logic disp_low_reg;
  logic halt_reg;
  logic stop_reg;
  logic [PA_W-1:0] pins_in_mode;
  logic pin_or;
  logic [PA_W-1:0] dbc_stable;
  logic dbc_change;
  logic psf_set;
  logic src_live;
  logic [3:0] hrf_set;
  logic [3:0] hrf_clr;
  logic [3:0] hrf_q;
  logic [3:0] irq_req_c;
  logic hr_pending;

  function automatic logic [3:0] f_dec(input logic [1:0] sel);
    f_dec = 4'h1 << sel;
  endfunction

  // fixed order: pre-divider, timer two, rfc, port
  function automatic logic [7:0] f_vec(input logic [3:0] req);
    if (req[hswc_pkg::IDX_PREDIV]) begin
      f_vec = hswc_pkg::VEC_PREDIV;
    end else if (req[hswc_pkg::IDX_TIMER2]) begin
      f_vec = hswc_pkg::VEC_TIMER2;
    end else if (req[hswc_pkg::IDX_RFC]) begin
      f_vec = hswc_pkg::VEC_RFC;
    end else if (req[hswc_pkg::IDX_PORT]) begin
      f_vec = hswc_pkg::VEC_PORT;
    end else begin
      f_vec = hswc_pkg::VEC_NONE;
    end
  endfunction

  assign pins_in_mode = PORT_A_WAKE_PINS_IN & PORT_A_INPUT_MODE_IN;
  assign pin_or = |pins_in_mode;
  // every function is frozen in stop, so sources cannot fire there
  assign src_live = (state_reg != hswc_pkg::ST_STOP);

  // the filter runs in halt too, only stop holds it
  hswc_debounce #(
    .W(PA_W),
    .CNT(DEBOUNCE_CYC)
  ) u_debounce (
    .clk_in(CLK_IN),
    .rstn_in(RESETN_IN),
    .hold_in(state_reg == hswc_pkg::ST_STOP),
    .pins_in(pins_in_mode),
    .stable_out(dbc_stable),
    .change_out(dbc_change)
  );

  assign psf_set = port_chg_en_reg & dbc_change;

  assign hrf_set = {SRC_IN.rfc_finish & src_live,
                    SRC_IN.timer2_ufl & src_live,
                    SRC_IN.prediv_ovf & src_live,
                    psf_set};
  assign hrf_clr = (CMD_IN.req_clr ? CMD_IN.req_clr_mask : 4'h0)
                 | (CMD_IN.irq_ack ? f_dec(CMD_IN.irq_ack_sel) : 4'h0);

  hswc_req_flag #(
    .W(4)
  ) u_halt_req (
    .clk_in(CLK_IN),
    .rstn_in(RESETN_IN),
    .set_in(hrf_set),
    .clr_in(hrf_clr),
    .flag_out(hrf_q)
  );

  assign hr_pending = port_start_flag_reg
                    | (hrf_q[hswc_pkg::IDX_PREDIV] & halt_en_reg[hswc_pkg::HEN_PREDIV])
                    | (hrf_q[hswc_pkg::IDX_TIMER2] & halt_en_reg[hswc_pkg::HEN_TIMER2])
                    | (hrf_q[hswc_pkg::IDX_RFC] & halt_en_reg[hswc_pkg::HEN_RFC]);

  assign irq_req_c = hrf_q & irq_en_reg
                   & {3'h7, ~port_irq_inh_reg};

  // configuration registers written by the sequencer
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      port_chg_en_reg <= hswc_pkg::PORT_CHG_RST;
      halt_en_reg <= hswc_pkg::HALT_EN_RST;
      stop_en_reg <= hswc_pkg::STOP_EN_RST;
    end else begin
      if (CMD_IN.cfg_port_wr) begin
        port_chg_en_reg <= CMD_IN.cfg_port_data;
      end
      if (CMD_IN.halt_en_wr) begin
        halt_en_reg <= CMD_IN.halt_en_data;
      end
      if (CMD_IN.stop_en_wr) begin
        stop_en_reg <= CMD_IN.stop_en_data;
      end
    end
  end

  // acceptance clears every enable, even one written in the same cycle
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      irq_en_reg <= hswc_pkg::IRQ_EN_RST;
    end else if (CMD_IN.irq_ack) begin
      irq_en_reg <= 4'h0;
    end else if (CMD_IN.irq_en_wr) begin
      irq_en_reg <= CMD_IN.irq_en_data;
    end
  end

  // port wake flags
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      port_stop_req_reg <= 1'b0;
      stop_wake_flag_reg <= 1'b0;
      port_start_flag_reg <= 1'b0;
      port_irq_inh_reg <= 1'b0;
    end else begin
      if (pin_or) begin
        port_stop_req_reg <= 1'b1;
      end else if (CMD_IN.req_clr && CMD_IN.req_clr_mask[hswc_pkg::IDX_PORT]) begin
        port_stop_req_reg <= 1'b0;
      end
      if (state_reg == hswc_pkg::ST_STOP && pin_or && stop_en_reg) begin
        stop_wake_flag_reg <= 1'b1;
      end else if (CMD_IN.req_clr && CMD_IN.req_clr_mask[hswc_pkg::IDX_PORT]) begin
        stop_wake_flag_reg <= 1'b0;
      end
      if (psf_set) begin
        port_start_flag_reg <= 1'b1;
      end else if (CMD_IN.cfg_port_wr) begin
        port_start_flag_reg <= 1'b0;
      end
      if (CMD_IN.irq_ack && CMD_IN.irq_ack_sel == hswc_pkg::IDX_PORT) begin
        port_irq_inh_reg <= 1'b1;
      end else if (CMD_IN.cfg_port_wr) begin
        port_irq_inh_reg <= 1'b0;
      end
    end
  end

  // mode sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      hswc_pkg::ST_RUN: begin
        if (CMD_IN.ret && resume_stop_reg) begin
          state_next = hswc_pkg::ST_STOP;
        end else if (CMD_IN.stop) begin
          if (pin_or) begin
            state_next = hswc_pkg::ST_RUN;
          end else if (stop_en_reg && port_stop_req_reg) begin
            state_next = hswc_pkg::ST_STOP_HALT;
          end else begin
            state_next = hswc_pkg::ST_STOP;
          end
        end else if (CMD_IN.halt && !hr_pending) begin
          state_next = hswc_pkg::ST_HALT;
        end
      end
      hswc_pkg::ST_HALT: begin
        if (hr_pending || CMD_IN.irq_ack) begin
          state_next = hswc_pkg::ST_RUN;
        end
      end
      hswc_pkg::ST_STOP: begin
        if (stop_en_reg && pin_or) begin
          state_next = hswc_pkg::ST_STOP_HALT;
        end
      end
      hswc_pkg::ST_STOP_HALT: begin
        if (hr_pending || CMD_IN.irq_ack) begin
          state_next = hswc_pkg::ST_RUN;
        end else if (!pin_or) begin
          state_next = hswc_pkg::ST_STOP;
        end
      end
      default: begin
        state_next = hswc_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state_reg <= hswc_pkg::ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // remembers that a service began in the stop-born halt
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      resume_stop_reg <= 1'b0;
    end else if (state_reg == hswc_pkg::ST_STOP_HALT && CMD_IN.irq_ack) begin
      resume_stop_reg <= 1'b1;
    end else if (state_reg == hswc_pkg::ST_RUN && CMD_IN.ret) begin
      resume_stop_reg <= 1'b0;
    end
  end

  // mode outputs follow the next state so they line up with state_reg
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      fetch_reg <= 1'b1;
      clk_run_reg <= 1'b1;
      disp_low_reg <= 1'b0;
      halt_reg <= 1'b0;
      stop_reg <= 1'b0;
    end else begin
      fetch_reg <= (state_next == hswc_pkg::ST_RUN);
      clk_run_reg <= (state_next != hswc_pkg::ST_STOP);
      disp_low_reg <= (state_next == hswc_pkg::ST_STOP);
      halt_reg <= (state_next == hswc_pkg::ST_HALT)
                || (state_next == hswc_pkg::ST_STOP_HALT);
      stop_reg <= (state_next == hswc_pkg::ST_STOP);
    end
  end

  // an acceptance drops requests at once so the sequencer never sees it twice
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      irq_req_reg <= 4'h0;
      vec_reg <= hswc_pkg::VEC_NONE;
    end else if (CMD_IN.irq_ack) begin
      irq_req_reg <= 4'h0;
      vec_reg <= hswc_pkg::VEC_NONE;
    end else begin
      irq_req_reg <= irq_req_c;
      vec_reg <= f_vec(irq_req_c);
    end
  end

  assign FETCH_EN_OUT = fetch_reg;
  assign CLK_RUN_OUT = clk_run_reg;
  assign DISP_LOW_OUT = disp_low_reg;
  assign HALT_OUT = halt_reg;
  assign STOP_OUT = stop_reg;
  assign IRQ_REQ_OUT = irq_req_reg;
  assign IRQ_VECTOR_OUT = vec_reg;
  assign PORT_START_FLAG_OUT = port_start_flag_reg;
  assign STOP_WAKE_FLAG_OUT = stop_wake_flag_reg;
  assign PORT_STOP_REQ_OUT = port_stop_req_reg;
  assign HALT_REQ_OUT = hrf_q;

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);

  property p_wake_flag;
    (state_reg == hswc_pkg::ST_STOP && pin_or && stop_en_reg) |=> stop_wake_flag_reg;
  endproperty
  a_wake_flag: assert property (p_wake_flag)
    else $error("stop wake flag not set");

  property p_stop_refuse;
    (state_reg == hswc_pkg::ST_RUN && CMD_IN.stop && pin_or && !CMD_IN.ret)
      |=> state_reg == hswc_pkg::ST_RUN && FETCH_EN_OUT;
  endproperty
  a_stop_refuse: assert property (p_stop_refuse)
    else $error("stop entered with port pins high");

  property p_start_flag;
    (port_chg_en_reg && dbc_change) |=> port_start_flag_reg;
  endproperty
  a_start_flag: assert property (p_start_flag)
    else $error("port change did not set start flag");

  property p_stop_release;
    (state_reg == hswc_pkg::ST_STOP && stop_en_reg && pin_or)
      |=> state_reg == hswc_pkg::ST_STOP_HALT && HALT_OUT && !STOP_OUT && CLK_RUN_OUT;
  endproperty
  a_stop_release: assert property (p_stop_release)
    else $error("stop not released by port pin");

  property p_restop;
    (state_reg == hswc_pkg::ST_STOP_HALT && !pin_or && !hr_pending && !CMD_IN.irq_ack)
      |=> STOP_OUT && DISP_LOW_OUT && !CLK_RUN_OUT;
  endproperty
  a_restop: assert property (p_restop)
    else $error("unconfirmed wake did not return to stop");

  property p_port_req;
    $rose(port_start_flag_reg) |-> hrf_q[hswc_pkg::IDX_PORT];
  endproperty
  a_port_req: assert property (p_port_req)
    else $error("start flag without port request");

  property p_port_inhibit;
    (port_irq_inh_reg && !CMD_IN.cfg_port_wr) |=> !IRQ_REQ_OUT[hswc_pkg::IDX_PORT];
  endproperty
  a_port_inhibit: assert property (p_port_inhibit)
    else $error("port interrupt raised while inhibited");

  property p_ack_clear;
    CMD_IN.irq_ack |=> irq_en_reg == 4'h0 && IRQ_REQ_OUT == 4'h0 ##1 IRQ_REQ_OUT == 4'h0;
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("acceptance left enables or requests");

  property p_halt_block;
    (state_reg == hswc_pkg::ST_RUN && CMD_IN.halt && hr_pending && !CMD_IN.stop && !CMD_IN.ret)
      |=> FETCH_EN_OUT && !HALT_OUT;
  endproperty
  a_halt_block: assert property (p_halt_block)
    else $error("halt entered with release pending");

  property p_fetch;
    FETCH_EN_OUT == (state_reg == hswc_pkg::ST_RUN);
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("fetch enable disagrees with mode");

  sequence s_stop_accept;
    state_reg == hswc_pkg::ST_STOP_HALT && CMD_IN.irq_ack;
  endsequence
  sequence s_serviced;
    state_reg == hswc_pkg::ST_RUN && resume_stop_reg;
  endsequence
  property p_stop_resume;
    s_stop_accept |=> s_serviced;
  endproperty
  a_stop_resume: assert property (p_stop_resume)
    else $error("service from stop not armed to resume");

  property p_vec_port;
    (IRQ_REQ_OUT == 4'h1) |-> IRQ_VECTOR_OUT == hswc_pkg::VEC_PORT;
  endproperty
  a_vec_port: assert property (p_vec_port)
    else $error("port interrupt vector wrong");

endmodule // hswc_halt_stop_ctrl

// ### logic/hswc_pkg.sv
/*
  hswc_pkg: constants, states and carrier types of the halt/stop wake control.
  Assumes one system clock; every command is a one-cycle pulse from the sequencer.
*/
package hswc_pkg;

  // port A wake pins
  localparam int PA_W = 4;
  // debounce length of the port A chatter filter, in clock cycles
  localparam int DEBOUNCE_CYC = 8;

  // halt request / interrupt index: port, pre-divider, timer two, rfc finish
  localparam logic [1:0] IDX_PORT = 2'h0;
  localparam logic [1:0] IDX_PREDIV = 2'h1;
  localparam logic [1:0] IDX_TIMER2 = 2'h2;
  localparam logic [1:0] IDX_RFC = 2'h3;

  // halt_wake_enables bit positions
  localparam int HEN_PREDIV = 0;
  localparam int HEN_TIMER2 = 1;
  localparam int HEN_RFC = 2;

  // values after reset
  localparam logic PORT_CHG_RST = 1'b0;
  localparam logic [2:0] HALT_EN_RST = 3'h0;
  localparam logic [3:0] IRQ_EN_RST = 4'h0;
  localparam logic STOP_EN_RST = 1'b0;

  // interrupt vectors
  localparam logic [7:0] VEC_PORT = 8'h14;
  localparam logic [7:0] VEC_PREDIV = 8'h1C;
  localparam logic [7:0] VEC_TIMER2 = 8'h20;
  localparam logic [7:0] VEC_RFC = 8'h28;
  localparam logic [7:0] VEC_NONE = 8'h00;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_HALT,
    ST_STOP,
    ST_STOP_HALT
  } hswc_state_t;

  typedef struct packed {
    logic halt;
    logic stop;
    logic cfg_port_wr;
    logic cfg_port_data;
    logic halt_en_wr;
    logic [2:0] halt_en_data;
    logic irq_en_wr;
    logic [3:0] irq_en_data;
    logic stop_en_wr;
    logic stop_en_data;
    logic req_clr;
    logic [3:0] req_clr_mask;
    logic irq_ack;
    logic [1:0] irq_ack_sel;
    logic ret;
  } hswc_cmd_t;

  typedef struct packed {
    logic prediv_ovf;
    logic timer2_ufl;
    logic rfc_finish;
  } hswc_src_t;

endpackage

// ### logic/hswc_req_flag.sv
/*
  hswc_req_flag: a vector of sticky request flags, set wins over clear.
  Assumes set and clear are one-cycle pulses in the system clock domain.
*/
`timescale 1ns/1ps
module hswc_req_flag #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // set and clear
  input wire logic [W-1:0] set_in,
  input wire logic [W-1:0] clr_in,
  // flags
  output logic [W-1:0] flag_out
);

  // a request landing on its own clear cycle is kept
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flag_out <= '0;
    end else begin
      flag_out <= set_in | (flag_out & ~clr_in);
    end
  end

  property p_flag_clr;
    @(posedge clk_in) disable iff (!rstn_in)
    ((clr_in & ~set_in) != '0) |=> ((flag_out & $past(clr_in & ~set_in)) == '0);
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("request flag not cleared");

  property p_flag_set;
    @(posedge clk_in) disable iff (!rstn_in)
    (set_in != '0) |=> ((flag_out & $past(set_in)) == $past(set_in));
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("request flag lost on set");

endmodule // hswc_req_flag

// ### logic/hswc_debounce.sv
/*
  hswc_debounce: chatter filter for the port A wake pins.
  Assumes pins are synchronous; hold_in freezes it while clocks are stopped.
*/
`timescale 1ns/1ps
module hswc_debounce #(
  parameter int W = 4,
  parameter int CNT = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // control and pins
  input wire logic hold_in,
  input wire logic [W-1:0] pins_in,
  // filtered result
  output logic [W-1:0] stable_out,
  output logic change_out
);

  localparam int CW = $clog2(CNT) + 1;

  logic [CW-1:0] cnt_reg;

  // a pin must differ from the accepted value for CNT cycles to count
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_reg <= '0;
      stable_out <= '0;
      change_out <= 1'b0;
    end else if (hold_in || pins_in == stable_out) begin
      cnt_reg <= '0;
      change_out <= 1'b0;
    end else if (cnt_reg == CW'(CNT - 1)) begin
      cnt_reg <= '0;
      stable_out <= pins_in;
      change_out <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      change_out <= 1'b0;
    end
  end

  property p_dbc_change;
    @(posedge clk_in) disable iff (!rstn_in)
    change_out |-> (stable_out == $past(pins_in)) && (stable_out != $past(stable_out));
  endproperty
  a_dbc_change: assert property (p_dbc_change)
    else $error("debounce change without new value");

endmodule // hswc_debounce

// ### verification/hswc_src_model.sv
/*
  hswc_src_model: wake source model (pre-divider, timer two, rfc finish).
  Assumes the bench asks for an event with fire_in; each event leaves as one pulse.
*/
`timescale 1ns/1ps
module hswc_src_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // event requests and latency
  input wire logic [2:0] fire_in,
  input wire logic [1:0] lat_in,
  // source pulses
  output hswc_pkg::hswc_src_t src_out
);
  logic [2:0] pend_reg;
  logic [1:0] cnt_reg;
  // real counters fire on their own schedule, so an event may lag lat_in cycles
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pend_reg <= 3'h0;
      cnt_reg <= 2'h0;
      src_out <= '0;
    end else begin
      src_out <= '0;
      if (fire_in != 3'h0) begin
        pend_reg <= fire_in;
        cnt_reg <= lat_in;
      end else if (pend_reg != 3'h0) begin
        if (cnt_reg == 2'h0) begin
          src_out <= {pend_reg[0], pend_reg[1], pend_reg[2]};
          pend_reg <= 3'h0;
        end else begin
          cnt_reg <= cnt_reg - 2'h1;
        end
      end
    end
  end
endmodule // hswc_src_model

// ### verification/tb_halt_stop_wake_control.sv
/*
  tb_halt_stop_wake_control: self-checking bench of the halt/stop wake control.
  Assumes the source model beside it; bench plays the sequencer and the pins.
*/
`timescale 1ns/1ps
module tb_halt_stop_wake_control;
  logic clk, rstn;
  hswc_pkg::hswc_cmd_t cmd;
  hswc_pkg::hswc_src_t src;
  logic [3:0] pins, imode, irq, hreq;
  logic [2:0] fire;
  logic [1:0] lat;
  logic fetch, crun, dlow, halt, stop, start, swake, preq;
  logic [7:0] vec_o;
  int seed, miscompares, total_checks, cyc, e, i;

  hswc_halt_stop_ctrl #(.DEBOUNCE_CYC(2)) i_hswc_halt_stop_ctrl (
    .CLK_IN(clk), .RESETN_IN(rstn), .CMD_IN(cmd), .SRC_IN(src),
    .PORT_A_WAKE_PINS_IN(pins), .PORT_A_INPUT_MODE_IN(imode),
    .FETCH_EN_OUT(fetch), .CLK_RUN_OUT(crun), .DISP_LOW_OUT(dlow),
    .HALT_OUT(halt), .STOP_OUT(stop), .IRQ_REQ_OUT(irq), .IRQ_VECTOR_OUT(vec_o),
    .PORT_START_FLAG_OUT(start), .STOP_WAKE_FLAG_OUT(swake),
    .PORT_STOP_REQ_OUT(preq), .HALT_REQ_OUT(hreq));
  hswc_src_model i_hswc_src_model (
    .clk_in(clk), .rstn_in(rstn), .fire_in(fire), .lat_in(lat), .src_out(src));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard: the whole run needs a few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    total_checks++;
    if (got !== ex) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // kind: 0 halt 1 stop 2 port cfg 3 halt en 4 irq en 5 stop en 6 clear 7 ack 8 return
  function automatic hswc_pkg::hswc_cmd_t mk(input int k, input logic [3:0] d);
    hswc_pkg::hswc_cmd_t c;
    c = '0;
    case (k)
      0: c.halt = 1'b1;
      1: c.stop = 1'b1;
      2: {c.cfg_port_wr, c.cfg_port_data} = {1'b1, d[0]};
      3: {c.halt_en_wr, c.halt_en_data} = {1'b1, d[2:0]};
      4: {c.irq_en_wr, c.irq_en_data} = {1'b1, d};
      5: {c.stop_en_wr, c.stop_en_data} = {1'b1, d[0]};
      6: {c.req_clr, c.req_clr_mask} = {1'b1, d};
      8: c.ret = 1'b1;
      default: {c.irq_ack, c.irq_ack_sel} = {1'b1, d[1:0]};
    endcase
    return c;
  endfunction

  function automatic logic [7:0] exp_vec(input int n);
    case (n)
      0: return 8'h14;
      1: return 8'h1C;
      2: return 8'h20;
      default: return 8'h28;
    endcase
  endfunction

  function automatic logic pick(input int s);
    case (s)
      0: return fetch;
      1: return halt;
      2: return stop;
      3: return start;
      default: return hreq[s-4];
    endcase
  endfunction

  task automatic do_cmd(input int k, input logic [3:0] d);
    @(posedge clk) cmd <= mk(k, d);
    @(posedge clk) cmd <= '0;
    #1;
  endtask

  task automatic fire_src(input int n);
    @(posedge clk) fire <= 3'h1 << n;
    lat <= 2'($random(seed));
    @(posedge clk) fire <= 3'h0;
    #1;
  endtask

  task automatic wait_for(input int s);
    int n;
    n = 0;
    while (pick(s) !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk($sformatf("wait %0d", s), 8'h0, (n == 60) ? 8'h1 : 8'h0);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  initial begin
    seed = 26;
    rstn = 1'b0;
    cmd = '0;
    pins = 4'h0;
    imode = 4'hF;
    fire = 3'h0;
    lat = 2'h0;
    settle(8);
    chk("reset mode", 8'hC0, {fetch, crun, dlow, halt, stop, start, swake, preq});
    chk("reset irq", 8'h00, {irq, hreq});
    @(posedge clk) rstn <= 1'b1;
    // halt released only by its enabled source; halt refused while pending
    for (int k = 0; k < 3; k++) begin
      do_cmd(6, 4'hF);
      do_cmd(3, 4'(1 << k));
      do_cmd(0, 4'h0);
      chk("halt entry", 8'h01, {fetch, halt});
      fire_src((k + 1) % 3);
      // long enough for the slowest source latency to reach the request flags
      settle(6);
      chk("halt kept", 8'h01, 8'(halt));
      fire_src(k);
      wait_for(0);
      do_cmd(0, 4'h0);
      chk("halt refused", 8'h00, 8'(halt));
    end
    $display("test halt done");
    // random enables against random sources, acceptance clears
    repeat (8) begin
      e = $random(seed) & 15;
      i = 1 + ($unsigned($random(seed)) % 3);
      do_cmd(6, 4'hF);
      do_cmd(4, 4'(e));
      fire_src(i - 1);
      wait_for(4 + i);
      settle(1);
      chk("irq req", e[i] ? 8'(1 << i) : 8'h0, 8'(irq));
      chk("irq vector", e[i] ? exp_vec(i) : 8'h0, vec_o);
      if (e[i]) begin
        do_cmd(7, 4'(i));
        chk("ack req", 8'h0, 8'(hreq[i]));
        fire_src(i - 1);
        wait_for(4 + i);
        settle(1);
        chk("enables cleared", 8'h0, 8'(irq));
      end
    end
    $display("test irq done");
    // stop refused, stop entry, short pin restops, held pin wakes
    @(posedge clk) pins <= 4'h4;
    do_cmd(1, 4'h0);
    chk("stop refused", 8'h01, {stop, fetch});
    chk("port stop req", 8'h01, 8'(preq));
    @(posedge clk) pins <= 4'h0;
    settle(6);
    do_cmd(2, 4'h1);
    do_cmd(6, 4'hF);
    do_cmd(5, 4'h1);
    do_cmd(4, 4'h1);
    do_cmd(1, 4'h0);
    chk("stop mode", 8'h03, {fetch, crun, dlow, stop});
    @(posedge clk) pins <= 4'h2;
    @(posedge clk) pins <= 4'h0;
    #1;
    chk("stop release", 8'h03, {halt, swake});
    chk("stop wake flag", 8'h01, 8'(swake));
    wait_for(2);
    @(posedge clk) pins <= 4'h8;
    wait_for(1);
    wait_for(0);
    chk("start flag", 8'h03, {start, hreq[0]});
    settle(1);
    chk("port irq", 8'h01, 8'(irq));
    chk("port vector", 8'h14, vec_o);
    do_cmd(7, 4'h0);
    chk("port ack", 8'h0, 8'(irq));
    do_cmd(4, 4'h1);
    // a fresh pin change raises the port request, the interrupt must stay low
    @(posedge clk) pins <= 4'h0;
    settle(6);
    chk("port inhibit", 8'h0, 8'(irq[0]));
    chk("port req kept", 8'h01, 8'(hreq[0]));
    do_cmd(2, 4'h1);
    chk("cfg clears start", 8'h0, 8'(start));
    do_cmd(1, 4'h0);
    chk("stop to halt", 8'h02, {halt, stop});
    $display("test stop done");
    @(posedge clk) rstn <= 1'b0;
    #1;
    chk("mid reset", 8'hC0, {fetch, crun, dlow, halt, stop, start, swake, preq});
    @(posedge clk) rstn <= 1'b1;
    settle(2);
    chk("after release", 8'hC0, {fetch, crun, dlow, halt, stop, start, swake, preq});
    $display("test reset done");
    // service begun in a stop-born halt goes back to stop on return
    do_cmd(5, 4'h1);
    do_cmd(4, 4'h4);
    do_cmd(1, 4'h0);
    @(posedge clk) pins <= 4'h1;
    wait_for(1);
    fire_src(1);
    wait_for(6);
    settle(1);
    chk("stop irq", 8'h04, 8'(irq));
    do_cmd(7, 4'h2);
    chk("stop service", 8'h02, {fetch, halt});
    chk("stop req cleared", 8'h0, 8'(hreq[2]));
    @(posedge clk) pins <= 4'h0;
    do_cmd(8, 4'h0);
    chk("resume stop", 8'h02, {stop, fetch});
    $display("test resume done");
    test_done();
  end
endmodule // tb_halt_stop_wake_control
